// [pkg/cac_consts.vh]
// constants for the core auxiliary and build configuration register bank
// assumes inclusion by bare name from the design files
`ifndef CAC_CONSTS_VH
`define CAC_CONSTS_VH

// system-register encoding fields shared by the bank
`define CAC_OP0 2'h3
`define CAC_OP1 3'h0
`define CAC_CRN 4'hF
`define CAC_CRM_AUX 4'h1
`define CAC_CRM_CFG 4'h0
`define CAC_OP2_AUX0 3'h0
`define CAC_OP2_AUX2 3'h1
`define CAC_OP2_AUX3 3'h2
`define CAC_OP2_CFG 3'h0

// one-hot select positions
`define CAC_SEL_W 4
`define CAC_SEL_AUX0 0
`define CAC_SEL_AUX2 1
`define CAC_SEL_AUX3 2
`define CAC_SEL_CFG 3
`define CAC_NUM_AUX 3

// privilege levels
`define CAC_EL0 2'h0
`define CAC_EL1 2'h1
`define CAC_EL2 2'h2
`define CAC_EL3 2'h3

// widths and reset values
`define CAC_AUX_W 64
`define CAC_CFG_W 32
`define CAC_AUX_RESET 64'h0000000000000000
`define CAC_CFG_PAD_W 29
`define CAC_CFG_PAD 29'h00000000
`define CAC_RDATA_ZERO 64'h0000000000000000
`define CAC_CFG_HI_ZERO 32'h00000000

// build configuration fields
`define CAC_CFG_SNOOP_BIT 2
`define CAC_CFG_ECC_MSB 1
`define CAC_CFG_ECC_LSB 0
`define CAC_ECC_ABSENT 2'h0
`define CAC_ECC_PRESENT 2'h1

`endif

// [verilog/cac_sysreg_decode.v]
// system-register encoding decoder for the auxiliary/config bank
// assumes the encoding fields are stable while req_valid is high
`timescale 1ns/10ps
`include "cac_consts.vh"

module cac_sysreg_decode (
  // encoding fields
  input wire [1:0] op0,
  input wire [2:0] op1,
  input wire [3:0] crn,
  input wire [3:0] crm,
  input wire [2:0] op2,
  // one-hot register select, all zero when unmapped
  output reg [`CAC_SEL_W-1:0] sel
);

  function match;
    input [3:0] crm_in;
    input [2:0] op2_in;
    input [3:0] crm_ref;
    input [2:0] op2_ref;
    begin
      match = (op0 == `CAC_OP0) && (op1 == `CAC_OP1) && (crn == `CAC_CRN) &&
              (crm_in == crm_ref) && (op2_in == op2_ref);
    end
  endfunction

  always @* begin
    sel = {`CAC_SEL_W{1'b0}};
    sel[`CAC_SEL_AUX0] = match(crm, op2, `CAC_CRM_AUX, `CAC_OP2_AUX0);
    sel[`CAC_SEL_AUX2] = match(crm, op2, `CAC_CRM_AUX, `CAC_OP2_AUX2);
    sel[`CAC_SEL_AUX3] = match(crm, op2, `CAC_CRM_AUX, `CAC_OP2_AUX3);
    sel[`CAC_SEL_CFG] = match(crm, op2, `CAC_CRM_CFG, `CAC_OP2_CFG);
  end

endmodule // cac_sysreg_decode

// [verilog/cac_write_gate.v]
// write permission and trap target for the auxiliary control registers
// assumes the enable bits and security state are held steady by the core
`timescale 1ns/10ps
`include "cac_consts.vh"

module cac_write_gate (
  // access context
  input wire [1:0] req_el,
  input wire is_aux0,
  // gating state
  input wire monitor_aux_write_enable,
  input wire hyp_aux_write_enable,
  input wire nonsecure_state_bit,
  // verdict
  output reg allow,
  output reg [1:0] trap_el
);

  reg hyp_ok;

  always @* begin
    hyp_ok = 1'b1;
    allow = 1'b1;
    trap_el = `CAC_EL3;
    case (req_el)
      `CAC_EL3: begin
        allow = 1'b1;
      end
      `CAC_EL2: begin
        allow = monitor_aux_write_enable;
        trap_el = `CAC_EL3;
      end
      `CAC_EL1: begin
        // secure state skips the hypervisor check for the first register only
        if (is_aux0) begin
          hyp_ok = hyp_aux_write_enable | ~nonsecure_state_bit;
        end else begin
          hyp_ok = hyp_aux_write_enable;
        end
        allow = monitor_aux_write_enable & hyp_ok;
        trap_el = hyp_ok ? `CAC_EL3 : `CAC_EL2;
      end
      default: begin
        allow = 1'b0;
      end
    endcase
  end

endmodule // cac_write_gate

// [verilog/cac_reg_bank.v]
// core auxiliary control and build configuration register bank
// assumes one request per cycle at most, answered on the next edge
`timescale 1ns/10ps
`include "cac_consts.vh"

module cac_reg_bank (
  // clock and reset
  input wire clk,
  input wire nrst,
  // system-register move request
  input wire req_valid,
  input wire req_write,
  input wire [1:0] req_el,
  input wire [1:0] req_op0,
  input wire [2:0] req_op1,
  input wire [3:0] req_crn,
  input wire [3:0] req_crm,
  input wire [2:0] req_op2,
  input wire [`CAC_AUX_W-1:0] req_wdata,
  // gating state from higher-level controls
  input wire monitor_aux_write_enable,
  input wire hyp_aux_write_enable,
  input wire nonsecure_state_bit,
  // build straps, caught while reset is held
  input wire cluster_snoop_unit_flag,
  input wire ecc_present,
  // response
  output wire rsp_valid,
  output wire [`CAC_AUX_W-1:0] rsp_rdata,
  output wire rsp_trap,
  output wire [1:0] rsp_trap_el,
  output wire rsp_undef
);

  wire [`CAC_SEL_W-1:0] sel;
  wire gate_allow;
  wire [1:0] gate_trap_el;
  wire [`CAC_NUM_AUX-1:0] aux_sel;
  wire hit;
  wire is_cfg;
  wire undef;
  wire aux_write;
  wire write_ok;
  reg [`CAC_AUX_W-1:0] aux_ff [0:`CAC_NUM_AUX-1];
  reg [`CAC_CFG_W-1:0] cfg_ff;
  reg rsp_valid_ff;
  reg [`CAC_AUX_W-1:0] rsp_rdata_ff;
  reg rsp_trap_ff;
  reg [1:0] rsp_trap_el_ff;
  reg rsp_undef_ff;
  reg [`CAC_AUX_W-1:0] nxt_rdata;
  genvar gi;

  cac_sysreg_decode u_decode (
    .op0(req_op0),
    .op1(req_op1),
    .crn(req_crn),
    .crm(req_crm),
    .op2(req_op2),
    .sel(sel)
  );

  cac_write_gate u_gate (
    .req_el(req_el),
    .is_aux0(sel[`CAC_SEL_AUX0]),
    .monitor_aux_write_enable(monitor_aux_write_enable),
    .hyp_aux_write_enable(hyp_aux_write_enable),
    .nonsecure_state_bit(nonsecure_state_bit),
    .allow(gate_allow),
    .trap_el(gate_trap_el)
  );

  assign aux_sel = sel[`CAC_SEL_AUX3:`CAC_SEL_AUX0];
  assign hit = |sel;
  assign is_cfg = sel[`CAC_SEL_CFG];
  // unmapped, user level, or a write to the read-only register
  assign undef = req_valid & (~hit | (req_el == `CAC_EL0) | (is_cfg & req_write));
  assign aux_write = req_valid & req_write & (|aux_sel) & ~undef;
  assign write_ok = aux_write & gate_allow;

  // one unbanked copy per register, no security-state index
  generate
    for (gi = 0; gi < `CAC_NUM_AUX; gi = gi + 1) begin : g_aux
      always @(posedge clk) begin
        if (!nrst) begin
          aux_ff[gi] <= `CAC_AUX_RESET;
        end else if (write_ok && aux_sel[gi]) begin
          aux_ff[gi] <= req_wdata;
        end
      end
    end
  endgenerate

  // straps are sampled while reset is held and frozen afterwards
  always @(posedge clk) begin
    if (!nrst) begin
      cfg_ff <= {`CAC_CFG_PAD, cluster_snoop_unit_flag,
                 (ecc_present ? `CAC_ECC_PRESENT : `CAC_ECC_ABSENT)};
    end
  end

  always @* begin
    nxt_rdata = `CAC_RDATA_ZERO;
    if (req_valid && !req_write && !undef) begin
      if (is_cfg) begin
        nxt_rdata = {`CAC_CFG_HI_ZERO, cfg_ff};
      end else if (aux_sel[`CAC_SEL_AUX0]) begin
        nxt_rdata = aux_ff[`CAC_SEL_AUX0];
      end else if (aux_sel[`CAC_SEL_AUX2]) begin
        nxt_rdata = aux_ff[`CAC_SEL_AUX2];
      end else if (aux_sel[`CAC_SEL_AUX3]) begin
        nxt_rdata = aux_ff[`CAC_SEL_AUX3];
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= `CAC_RDATA_ZERO;
      rsp_trap_ff <= 1'b0;
      rsp_trap_el_ff <= `CAC_EL0;
      rsp_undef_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= req_valid;
      rsp_rdata_ff <= nxt_rdata;
      rsp_trap_ff <= aux_write & ~gate_allow;
      rsp_trap_el_ff <= (aux_write & ~gate_allow) ? gate_trap_el : `CAC_EL0;
      rsp_undef_ff <= undef;
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rsp_rdata_ff;
  assign rsp_trap = rsp_trap_ff;
  assign rsp_trap_el = rsp_trap_el_ff;
  assign rsp_undef = rsp_undef_ff;

endmodule // cac_reg_bank

// [bench/cac_bank_assertions.sv]
// assertions for the auxiliary control and build configuration bank
// assumes binding onto the ports of cac_reg_bank
`timescale 1ns/10ps
module cac_bank_assertions (
  // clock and reset
  input wire clk,
  input wire nrst,
  // request
  input wire req_valid,
  input wire req_write,
  input wire [1:0] req_el,
  input wire [1:0] req_op0,
  input wire [2:0] req_op1,
  input wire [3:0] req_crn,
  input wire [3:0] req_crm,
  input wire [2:0] req_op2,
  // gating
  input wire monitor_aux_write_enable,
  input wire hyp_aux_write_enable,
  input wire nonsecure_state_bit,
  // response
  input wire rsp_valid,
  input wire [63:0] rsp_rdata,
  input wire rsp_trap,
  input wire [1:0] rsp_trap_el,
  input wire rsp_undef
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire hit = req_valid && req_op0 == 2'h3 && req_op1 == 3'h0 && req_crn == 4'hF;
  wire cfg = hit && req_crm == 4'h0 && req_op2 == 3'h0;
  wire wr0 = hit && req_write && req_crm == 4'h1 && req_op2 == 3'h0;
  wire wr23 = hit && req_write && req_crm == 4'h1 && (req_op2 == 3'h1 || req_op2 == 3'h2);
  wire mon = monitor_aux_write_enable;
  wire hyp = hyp_aux_write_enable;
  wire ns = nonsecure_state_bit;
  chk_rsp_next: assert property (req_valid |=> rsp_valid) else $error("missing response");
  chk_idle_quiet: assert property (!req_valid |=> !(rsp_valid || rsp_trap || rsp_undef))
    else $error("response without request");
  chk_trap_target: assert property (rsp_trap |-> !rsp_undef && rsp_trap_el[1])
    else $error("bad trap target");
  chk_el2_deny: assert property (wr0 && req_el == 2'h2 && !mon
    |=> rsp_trap && rsp_trap_el == 2'h3) else $error("hypervisor write not trapped");
  chk_aux23_hyp: assert property (wr23 && req_el == 2'h1 && mon && !hyp
    |=> rsp_trap && rsp_trap_el == 2'h2) else $error("secondary register write not trapped");
  chk_el1_allow: assert property (wr0 && req_el == 2'h1 && mon && (hyp || !ns)
    |=> rsp_valid && !rsp_trap && !rsp_undef) else $error("kernel write refused");
  chk_hyp_deny: assert property (wr0 && req_el == 2'h1 && mon && !hyp && ns
    |=> rsp_trap && rsp_trap_el == 2'h2) else $error("kernel write not trapped");
  chk_cfg_hi_zero: assert property (cfg && !req_write && req_el != 2'h0
    |=> !rsp_undef && rsp_rdata[63:3] == 61'h0) else $error("config upper bits set");
  chk_cfg_wr_undef: assert property (cfg && req_write |=> rsp_undef && !rsp_trap)
    else $error("config write accepted");
  cover property (rsp_trap && rsp_trap_el == 2'h3);
  cover property (rsp_trap && rsp_trap_el == 2'h2);
  cover property (rsp_undef);
endmodule // cac_bank_assertions

bind cac_reg_bank cac_bank_assertions cac_bank_assertions_inst (.*);

// [bench/tb.sv]
// self-checking bench for the auxiliary control and build configuration bank
// assumes the bank answers every request on the following edge
`timescale 1ns/10ps
module tb;
  typedef struct {int w; int el; int s; int g; logic [63:0] d;
    int u; int t; int te; logic [63:0] rd;} cac_row_t;
  logic clk = 0, nrst = 0, req_valid = 0, req_write = 0, mon = 0, hyp = 0, ns = 0;
  logic snoop = 1, ecc = 1;
  logic [1:0] req_el = 0;
  logic [1:0] req_op0 = 2'h3;
  logic [2:0] req_op1 = 3'h0;
  logic [3:0] req_crn = 4'hF;
  logic [3:0] req_crm = 0;
  logic [2:0] req_op2 = 0;
  logic [63:0] req_wdata = 0;
  wire rsp_valid, rsp_trap, rsp_undef;
  wire [1:0] rsp_trap_el;
  wire [63:0] rsp_rdata;
  int n_errors = 0, cmp_count = 0;
  cac_row_t rows[19];
  always #2.5 clk = ~clk;
  cac_reg_bank cac_reg_bank_inst (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_write(req_write), .req_el(req_el), .req_op0(req_op0), .req_op1(req_op1),
    .req_crn(req_crn), .req_crm(req_crm), .req_op2(req_op2), .req_wdata(req_wdata),
    .monitor_aux_write_enable(mon), .hyp_aux_write_enable(hyp), .nonsecure_state_bit(ns),
    .cluster_snoop_unit_flag(snoop), .ecc_present(ecc), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_trap(rsp_trap), .rsp_trap_el(rsp_trap_el),
    .rsp_undef(rsp_undef));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // s selects aux0, aux2, aux3, config, unmapped; g packs monitor, hypervisor, nonsecure
  task automatic access(input cac_row_t r);
    @(posedge clk);
    #1;
    req_valid = 1;
    req_write = r.w[0];
    req_el = r.el[1:0];
    {mon, hyp, ns} = r.g[2:0];
    req_wdata = r.d;
    req_crm = (r.s == 3) ? 4'h0 : 4'h1;
    req_op2 = (r.s > 3) ? 3'h7 : (r.s == 3) ? 3'h0 : r.s[2:0];
    @(posedge clk);
    #1;
    req_valid = 0;
    check({rsp_valid, rsp_undef, rsp_trap, rsp_trap_el}, {1'h1, r.u[0], r.t[0], r.te[1:0]});
    check(rsp_rdata, r.rd);
  endtask
  task automatic do_reset(input logic s, input logic e);
    nrst = 0;
    snoop = s;
    ecc = e;
    repeat (20) @(posedge clk);
    #1 nrst = 1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #5000;
    n_errors++;
    print_verdict();
  end
  initial begin
    rows[0] = '{1, 1, 0, 7, 64'hA1, 0, 0, 0, 64'h0};
    rows[1] = '{0, 1, 0, 7, 64'h0, 0, 0, 0, 64'hA1};
    rows[2] = '{1, 1, 0, 5, 64'hFF, 0, 1, 2, 64'h0};
    rows[3] = '{0, 1, 0, 5, 64'h0, 0, 0, 0, 64'hA1};
    rows[4] = '{1, 1, 0, 4, 64'hA2, 0, 0, 0, 64'h0};
    rows[5] = '{0, 1, 0, 1, 64'h0, 0, 0, 0, 64'hA2};
    rows[6] = '{1, 1, 0, 3, 64'hFF, 0, 1, 3, 64'h0};
    rows[7] = '{1, 2, 0, 3, 64'hFF, 0, 1, 3, 64'h0};
    rows[8] = '{0, 3, 0, 0, 64'h0, 0, 0, 0, 64'hA2};
    rows[9] = '{1, 2, 0, 4, 64'hA3, 0, 0, 0, 64'h0};
    rows[10] = '{1, 1, 1, 7, 64'hB2, 0, 0, 0, 64'h0};
    rows[11] = '{1, 2, 2, 4, 64'hB3, 0, 0, 0, 64'h0};
    rows[12] = '{1, 1, 2, 4, 64'hFF, 0, 1, 2, 64'h0};
    rows[13] = '{1, 2, 1, 0, 64'hFF, 0, 1, 3, 64'h0};
    rows[14] = '{0, 1, 1, 0, 64'h0, 0, 0, 0, 64'hB2};
    rows[15] = '{0, 1, 2, 0, 64'h0, 0, 0, 0, 64'hB3};
    rows[16] = '{1, 3, 3, 7, 64'hFF, 1, 0, 0, 64'h0};
    rows[17] = '{0, 1, 3, 0, 64'h0, 0, 0, 0, 64'h5};
    rows[18] = '{0, 1, 4, 0, 64'h0, 1, 0, 0, 64'h0};
    do_reset(1, 1);
    foreach (rows[i]) access(rows[i]);
    access('{0, 0, 0, 7, 64'h0, 1, 0, 0, 64'h0});
    // encodings off by one fixed field must not reach any register
    req_crn = 4'hE;
    access('{0, 1, 0, 7, 64'h0, 1, 0, 0, 64'h0});
    req_crn = 4'hF;
    req_op1 = 3'h1;
    access('{0, 1, 3, 7, 64'h0, 1, 0, 0, 64'h0});
    req_op1 = 3'h0;
    req_op0 = 2'h2;
    access('{1, 3, 0, 7, 64'hFF, 1, 0, 0, 64'h0});
    req_op0 = 2'h3;
    access('{0, 3, 0, 7, 64'h0, 0, 0, 0, 64'hA3});
    // second reset in mid-run with other strap values
    do_reset(0, 0);
    access('{0, 1, 3, 0, 64'h0, 0, 0, 0, 64'h0});
    access('{0, 1, 0, 0, 64'h0, 0, 0, 0, 64'h0});
    do_reset(0, 1);
    access('{0, 2, 3, 0, 64'h0, 0, 0, 0, 64'h1});
    print_verdict();
  end
endmodule // tb
